// >>> shared/psp_params.svh
// Purpose: Constants for the pipelined burst SRAM port and its bus master
// Assumes: One word is two lanes of nine bits
// Notes: Included by the package only
`ifndef PSP_PARAMS_SVH
`define PSP_PARAMS_SVH
`define PSP_LANES 2
`define PSP_LANE_W 9
`define PSP_HI_W 16
`define PSP_LSB_W 2
`define PSP_ADDR_W 18
`define PSP_DEPTH 262144
`define PSP_BEATS_LEFT 2'h3
`define PSP_PIPE_W 3
`define PSP_ALL_LANES 2'h3
`define PSP_NO_LANES 2'h0
`define PSP_BEAT_STEP 2'h1
`endif

// >>> shared/psp_pkg.sv
// Purpose: Types shared by both ends of the burst SRAM port
// Assumes: Constants come from the params header
// Notes: Structs hold the register state of each module; lane storage stays outside them
`include "psp_params.svh"
package psp_pkg;
   typedef logic [`PSP_LANES-1:0][`PSP_LANE_W-1:0] psp_word_t;
   typedef logic [`PSP_LANES-1:0] psp_be_t;
   typedef logic [`PSP_HI_W-1:0] psp_hi_t;
   typedef logic [`PSP_LSB_W-1:0] psp_lsb_t;
   typedef logic [`PSP_ADDR_W-1:0] psp_addr_t;

   typedef enum logic [1:0] {
      PSP_IDLE = 2'h0,
      PSP_BEAT = 2'h1,
      PSP_DESEL = 2'h3,
      PSP_WAIT = 2'h2
   } psp_host_st_t;

   typedef struct packed {
      logic active;
      psp_hi_t addr_hi;
      psp_lsb_t base;
      psp_lsb_t cnt;
      logic rd;
      logic wr;
      psp_be_t be;
      psp_word_t wdata;
      psp_word_t q;
      logic q_valid;
   } psp_dev_state_t;

   typedef struct packed {
      psp_host_st_t st;
      psp_lsb_t left;
      logic reading;
      logic [`PSP_PIPE_W-1:0] pipe;
      logic ctrl_addr_strobe_n_n;
      logic adv_n;
      logic se1_n;
      psp_addr_t addr;
      logic gw_n;
      logic sw_n;
      psp_be_t sb_n;
      psp_word_t wdata;
      psp_be_t lane_oe;
      logic oe_n;
      psp_word_t rdata;
      logic rdata_valid;
   } psp_host_state_t;
endpackage : psp_pkg

// >>> shared/psp_if.sv
// Purpose: Pin bundle between the burst SRAM and its bus master
// Assumes: Each end gives per-lane drive enables
// Notes: Lanes resolve here; an undriven lane reads zero
`timescale 1ns/1ps
interface psp_if (
   input wire logic clk_sys
);
   import psp_pkg::*;
   psp_hi_t word_address_in;
   logic burst_lsb_hi;
   logic burst_lsb_lo;
   logic ctrl_addr_strobe_n;
   logic cpu_addr_strobe_n;
   logic burst_step_n;
   psp_be_t byte_write_n;
   logic chip_enable_primary_n;
   logic chip_enable_depth_hi;
   logic chip_enable_depth_lo_n;
   logic global_write_n;
   logic byte_select_write_n;
   logic out_enable_n;
   logic burst_order_sel;
   psp_word_t dev_lane_out;
   psp_be_t dev_lane_oe;
   psp_word_t host_lane_out;
   psp_be_t host_lane_oe;
   psp_word_t data_io_lane;

   always_comb begin
      for (int i = 0; i < `PSP_LANES; i++) begin
         if (dev_lane_oe[i]) begin
            data_io_lane[i] = dev_lane_out[i];
         end else if (host_lane_oe[i]) begin
            data_io_lane[i] = host_lane_out[i];
         end else begin
            data_io_lane[i] = '0;
         end
      end
   end

   modport device (
      input word_address_in, burst_lsb_hi, burst_lsb_lo, ctrl_addr_strobe_n,
      input cpu_addr_strobe_n, burst_step_n, byte_write_n, chip_enable_primary_n,
      input chip_enable_depth_hi, chip_enable_depth_lo_n, global_write_n,
      input byte_select_write_n, out_enable_n, burst_order_sel, data_io_lane,
      output dev_lane_out, dev_lane_oe
   );
   modport host (
      output word_address_in, burst_lsb_hi, burst_lsb_lo, ctrl_addr_strobe_n,
      output cpu_addr_strobe_n, burst_step_n, byte_write_n, chip_enable_primary_n,
      output chip_enable_depth_hi, chip_enable_depth_lo_n, global_write_n,
      output byte_select_write_n, out_enable_n, burst_order_sel,
      output host_lane_out, host_lane_oe,
      input data_io_lane
   );
endinterface : psp_if

// >>> hw/psp_sram.sv
// Purpose: Pipelined burst SRAM, 256K words of two nine-bit lanes
// Assumes: Pins are synchronous to clk_sys; rst is a synchronous clear
// Notes: Write lands one edge after its command is sampled
`timescale 1ns/1ps
module psp_sram (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Pins
   psp_if.device pins
);
   import psp_pkg::*;

   psp_dev_state_t s;
   psp_dev_state_t next_s;
   psp_word_t rd_word;
   logic sel;
   logic cpu_load;
   logic ctrl_load;
   logic is_wr;
   psp_be_t wr_be;
   psp_addr_t idx;

   // Burst index from the loaded address and the live order pin
   psp_beat_addr u_psp_beat_addr (
      .addr_hi(s.addr_hi),
      .base(s.base),
      .cnt(s.cnt),
      .order_sel(pins.burst_order_sel),
      .idx(idx)
   );

   // Enables and strobes decoded once, ahead of the state update
   always_comb begin
      sel = ~pins.chip_enable_primary_n
         & pins.chip_enable_depth_hi
         & ~pins.chip_enable_depth_lo_n;
      // A processor strobe counts only with primary enable low
      cpu_load = ~pins.cpu_addr_strobe_n & ~pins.chip_enable_primary_n;
      ctrl_load = ~pins.ctrl_addr_strobe_n;
      // Write needs global, or select with a lane
      is_wr = ~pins.global_write_n
         | (~pins.byte_select_write_n & ~(&pins.byte_write_n));
      if (~pins.global_write_n) begin
         wr_be = `PSP_ALL_LANES;
      end else if (~pins.byte_select_write_n) begin
         wr_be = ~pins.byte_write_n;
      end else begin
         wr_be = `PSP_NO_LANES;
      end
   end

   always_comb begin
      next_s = s;
      next_s.rd = 1'b0;
      next_s.wr = 1'b0;
      next_s.wdata = pins.data_io_lane;
      if (cpu_load) begin
         // Write pins are not looked at on a processor strobe
         next_s.active = sel;
         if (sel) begin
            next_s.addr_hi = pins.word_address_in;
            next_s.base = {pins.burst_lsb_hi, pins.burst_lsb_lo};
            next_s.cnt = '0;
            next_s.rd = 1'b1;
         end
      end else if (ctrl_load) begin
         // Not selected: this strobe deselects
         next_s.active = sel;
         if (sel) begin
            next_s.addr_hi = pins.word_address_in;
            next_s.base = {pins.burst_lsb_hi, pins.burst_lsb_lo};
            next_s.cnt = '0;
            next_s.wr = is_wr;
            next_s.rd = ~is_wr;
            next_s.be = wr_be;
         end
      end else if (s.active) begin
         // Suspend repeats the current address
         if (~pins.burst_step_n) begin
            next_s.cnt = s.cnt + `PSP_BEAT_STEP;
         end
         next_s.wr = is_wr;
         next_s.rd = ~is_wr;
         next_s.be = wr_be;
      end
      // Array read lands in the output register one edge later
      next_s.q_valid = s.rd;
      if (s.rd) begin
         next_s.q = rd_word;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // One lane instance per byte lane; storage too large to pack in state
   for (genvar g = 0; g < `PSP_LANES; g++) begin : g_lane
      psp_lane #(
         .LANE(g)
      ) u_psp_lane (
         .clk_sys(clk_sys),
         .wr_en(s.wr & s.be[g]),
         .idx(idx),
         .wdata(s.wdata),
         .rd_lane(rd_word[g]),
         .q_valid(s.q_valid),
         .q(s.q),
         .out_enable_n(pins.out_enable_n),
         .lane_out(pins.dev_lane_out[g]),
         .lane_oe(pins.dev_lane_oe[g])
      );
   end
endmodule : psp_sram

// Burst index: upper bits held, low bits follow the order pin
module psp_beat_addr (
   // Burst state
   input wire psp_pkg::psp_hi_t addr_hi,
   input wire psp_pkg::psp_lsb_t base,
   input wire psp_pkg::psp_lsb_t cnt,
   // Live order strap
   input wire logic order_sel,
   // Array index
   output psp_pkg::psp_addr_t idx
);
   import psp_pkg::*;
   psp_lsb_t lsb;

   // Order pin is used live, never registered
   always_comb begin
      if (order_sel) begin
         lsb = base ^ cnt;
      end else begin
         lsb = base + cnt;
      end
      // Upper bits never move within a burst
      idx = {addr_hi, lsb};
   end
endmodule : psp_beat_addr

// One byte lane: its own storage and output driver
module psp_lane #(
   parameter int LANE = 0
) (
   // Clock
   input wire logic clk_sys,
   // Array side
   input wire logic wr_en,
   input wire psp_pkg::psp_addr_t idx,
   input wire psp_pkg::psp_word_t wdata,
   output logic [`PSP_LANE_W-1:0] rd_lane,
   // Output register side
   input wire logic q_valid,
   input wire psp_pkg::psp_word_t q,
   // Asynchronous gate
   input wire logic out_enable_n,
   // Lane pins
   output logic [`PSP_LANE_W-1:0] lane_out,
   output logic lane_oe
);
   import psp_pkg::*;
   // Parent keeps the output register; a lane only stores and drives

   // Each lane keeps its own write control
   logic [`PSP_LANE_W-1:0] mem [0:`PSP_DEPTH-1];

   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem[idx] <= wdata[LANE];
      end
   end

   // Read is combinational; the parent registers it
   assign rd_lane = mem[idx];
   // Gate has no clock in its path, so drive tracks the pin
   assign lane_oe = q_valid & ~out_enable_n;
   assign lane_out = q[LANE];
endmodule : psp_lane

// >>> hw/psp_host.sv
// Purpose: Bus master that runs single and four-beat bursts on the SRAM
// Assumes: Burst order comes in as a static strap from the user side
// Notes: Writes wait for reads to drain so the bus never fights
`timescale 1ns/1ps
module psp_host (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Static configuration
   input wire logic order_interleaved,
   // First beat request
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic req_burst,
   input wire psp_pkg::psp_addr_t req_addr,
   input wire psp_pkg::psp_be_t req_be,
   input wire psp_pkg::psp_word_t req_wdata,
   // Later beats
   input wire logic beat_valid,
   output logic beat_ready,
   input wire psp_pkg::psp_word_t beat_wdata,
   // Read return
   output psp_pkg::psp_word_t rdata,
   output logic rdata_valid,
   // Pins
   psp_if.host pins
);
   import psp_pkg::*;

   psp_host_state_t s;
   psp_host_state_t next_s;
   logic issue_rd;

   assign req_ready = (s.st == PSP_IDLE);
   assign beat_ready = (s.st == PSP_BEAT);

   always_comb begin
      next_s = s;
      issue_rd = 1'b0;
      next_s.ctrl_addr_strobe_n_n = 1'b1;
      next_s.adv_n = 1'b1;
      next_s.se1_n = 1'b0;
      next_s.gw_n = 1'b1;
      next_s.sw_n = 1'b1;
      next_s.sb_n = '1;
      next_s.lane_oe = '0;
      case (s.st)
         PSP_IDLE: begin
            if (req_valid) begin
               next_s.ctrl_addr_strobe_n_n = 1'b0;
               next_s.addr = req_addr;
               next_s.reading = ~req_write;
               next_s.wdata = req_wdata;
               next_s.left = req_burst ? `PSP_BEATS_LEFT : '0;
               next_s.st = req_burst ? PSP_BEAT : PSP_DESEL;
               issue_rd = ~req_write;
               if (req_write) begin
                  next_s.lane_oe = '1;
                  if (&req_be) begin
                     next_s.gw_n = 1'b0;
                  end else begin
                     next_s.sw_n = 1'b0;
                     next_s.sb_n = ~req_be;
                  end
               end
            end
         end
         PSP_BEAT: begin
            // Write pins repeat so each beat before the first suspend keeps its lanes
            next_s.gw_n = s.gw_n;
            next_s.sw_n = s.sw_n;
            next_s.sb_n = s.sb_n;
            next_s.lane_oe = s.lane_oe;
            if (beat_valid) begin
               next_s.adv_n = 1'b0;
               next_s.wdata = beat_wdata;
               next_s.left = s.left - `PSP_BEAT_STEP;
               issue_rd = s.reading;
               if (s.left == `PSP_BEAT_STEP) begin
                  next_s.st = PSP_DESEL;
               end
            end else begin
               // Suspend: no step, lanes not written
               next_s.gw_n = 1'b1;
               next_s.sw_n = 1'b1;
               next_s.lane_oe = '0;
            end
         end
         PSP_DESEL: begin
            next_s.ctrl_addr_strobe_n_n = 1'b0;
            next_s.se1_n = 1'b1;
            next_s.st = PSP_WAIT;
         end
         PSP_WAIT: begin
            // Output enable must fall back before any write
            if (s.pipe == '0) begin
               next_s.reading = 1'b0;
               next_s.st = PSP_IDLE;
            end
         end
         default: begin
            next_s.st = PSP_IDLE;
         end
      endcase
      next_s.pipe = {s.pipe[`PSP_PIPE_W-2:0], issue_rd};
      next_s.oe_n = ~(next_s.reading | (|next_s.pipe));
      next_s.rdata_valid = s.pipe[`PSP_PIPE_W-1];
      if (s.pipe[`PSP_PIPE_W-1]) begin
         next_s.rdata = pins.data_io_lane;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s <= '0;
         s.ctrl_addr_strobe_n_n <= 1'b1;
         s.adv_n <= 1'b1;
         s.se1_n <= 1'b1;
         s.gw_n <= 1'b1;
         s.sw_n <= 1'b1;
         s.sb_n <= '1;
         s.oe_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign pins.word_address_in = s.addr[`PSP_ADDR_W-1:`PSP_LSB_W];
   assign pins.burst_lsb_hi = s.addr[1];
   assign pins.burst_lsb_lo = s.addr[0];
   assign pins.ctrl_addr_strobe_n = s.ctrl_addr_strobe_n_n;
   // Reads start on both strobes; deselect then tries the blocked processor strobe
   assign pins.cpu_addr_strobe_n = s.ctrl_addr_strobe_n_n | ~s.reading;
   assign pins.burst_step_n = s.adv_n;
   assign pins.byte_write_n = s.sb_n;
   assign pins.chip_enable_primary_n = s.se1_n;
   assign pins.chip_enable_depth_hi = 1'b1;
   assign pins.chip_enable_depth_lo_n = 1'b0;
   assign pins.global_write_n = s.gw_n;
   assign pins.byte_select_write_n = s.sw_n;
   assign pins.out_enable_n = s.oe_n;
   assign pins.burst_order_sel = order_interleaved;
   assign pins.host_lane_out = s.wdata;
   assign pins.host_lane_oe = s.lane_oe;
   assign rdata = s.rdata;
   assign rdata_valid = s.rdata_valid;
endmodule : psp_host

// >>> verif/psp_port_asserts.sv
// Purpose: Pin checks between burst SRAM and its master
// Assumes: Read data drives two edges after its command
// Notes: Watches the interface signals only
`timescale 1ns/1ps
module psp_port_asserts (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Control pins
   input wire logic ctrl_addr_strobe_n,
   input wire logic burst_step_n,
   input wire psp_pkg::psp_be_t byte_write_n,
   input wire logic chip_enable_primary_n,
   input wire logic chip_enable_depth_hi,
   input wire logic chip_enable_depth_lo_n,
   input wire logic global_write_n,
   input wire logic byte_select_write_n,
   input wire logic out_enable_n,
   input wire logic burst_order_sel,
   // Lane enables
   input wire psp_pkg::psp_be_t dev_lane_oe,
   input wire psp_pkg::psp_be_t host_lane_oe
);
   import psp_pkg::*;
   logic wr_pins;
   logic sel;
   assign wr_pins = !global_write_n || (!byte_select_write_n && byte_write_n != 2'h3);
   assign sel = !chip_enable_primary_n && chip_enable_depth_hi && !chip_enable_depth_lo_n;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   AST_OE_GATE: assert property (out_enable_n |-> dev_lane_oe == 2'h0)
      else $error("Lanes driven with output enable high");
   AST_READ_DRIVES: assert property (!ctrl_addr_strobe_n && sel && !wr_pins |=> ##1
      (out_enable_n || dev_lane_oe == 2'h3))
      else $error("Read data missing two edges after command");
   AST_DESELECT: assert property (!ctrl_addr_strobe_n && chip_enable_primary_n |=> ##1
      dev_lane_oe == 2'h0)
      else $error("Lanes driven after deselect");
   AST_WRITE_QUIET: assert property (wr_pins && (!burst_step_n || !ctrl_addr_strobe_n && sel)
      |=> ##1 dev_lane_oe == 2'h0)
      else $error("Lanes driven after write");
   AST_DRIVE_CAUSE: assert property (dev_lane_oe != 2'h0 |-> $past(!wr_pins, 2))
      else $error("Lanes driven without a read");
   AST_ORDER_STATIC: assert property ($stable(burst_order_sel))
      else $error("Burst order changed in operation");
   AST_NO_FIGHT: assert property ((dev_lane_oe & host_lane_oe) == 2'h0)
      else $error("Both ends drive one lane");
   AST_HOST_OE_OFF: assert property (host_lane_oe != 2'h0 |-> out_enable_n)
      else $error("Output enable low while host drives");
endmodule : psp_port_asserts

// >>> verif/pipelined_burst_sram_port_bench.sv
// Purpose: Random bursts and byte writes through master and SRAM
// Assumes: Memory model holds only bench writes
// Notes: Order changes only under reset
`timescale 1ns/1ps
module pipelined_burst_sram_port_bench;
   import psp_pkg::*;
   logic clk_sys = 1'b0;
   logic rst, order_interleaved, req_valid, req_ready, req_write, req_burst;
   logic beat_valid, beat_ready, rdata_valid;
   psp_addr_t req_addr, a;
   psp_be_t req_be;
   psp_word_t req_wdata, beat_wdata, rdata;
   int mismatches, samples_checked, seed;
   psp_word_t mem [psp_addr_t];
   psp_word_t exp_q [$];
   always #50 clk_sys = ~clk_sys;
   psp_if pins (.clk_sys(clk_sys));
   psp_sram u_psp_sram (.clk_sys(clk_sys), .rst(rst), .pins(pins));
   psp_host u_psp_host (.clk_sys(clk_sys), .rst(rst), .order_interleaved(order_interleaved),
      .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
      .req_burst(req_burst), .req_addr(req_addr), .req_be(req_be), .req_wdata(req_wdata),
      .beat_valid(beat_valid), .beat_ready(beat_ready), .beat_wdata(beat_wdata),
      .rdata(rdata), .rdata_valid(rdata_valid), .pins(pins));
   psp_port_asserts u_psp_port_asserts (.clk_sys(clk_sys), .rst(rst),
      .ctrl_addr_strobe_n(pins.ctrl_addr_strobe_n), .burst_step_n(pins.burst_step_n),
      .byte_write_n(pins.byte_write_n), .chip_enable_primary_n(pins.chip_enable_primary_n),
      .chip_enable_depth_hi(pins.chip_enable_depth_hi),
      .chip_enable_depth_lo_n(pins.chip_enable_depth_lo_n),
      .global_write_n(pins.global_write_n), .byte_select_write_n(pins.byte_select_write_n),
      .out_enable_n(pins.out_enable_n), .burst_order_sel(pins.burst_order_sel),
      .dev_lane_oe(pins.dev_lane_oe), .host_lane_oe(pins.host_lane_oe));
   function automatic psp_addr_t beat_addr(input psp_addr_t ad, input logic ord, input int k);
      psp_lsb_t n;
      n = ord ? ad[1:0] ^ 2'(k) : ad[1:0] + 2'(k);
      return {ad[17:2], n};
   endfunction : beat_addr
   task automatic check_word(input psp_word_t exp, input psp_word_t got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("Error rdata expected %h seen %h", exp, got);
      end
   endtask : check_word
   task automatic check_count(input int exp, input int got);
      samples_checked++;
      if (got != exp) begin
         mismatches++;
         $display("Error read_count expected %0d seen %0d", exp, got);
      end
   endtask : check_count
   task automatic report_and_stop;
      if (mismatches == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop
   task automatic do_reset(input logic ord);
      rst <= 1'b1;
      order_interleaved <= ord;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
   endtask : do_reset
   // Reads queue the model word; writes touch only enabled lanes
   task automatic model(input psp_addr_t ad, input logic wr, input psp_be_t be,
      input psp_word_t w);
      if (!wr) begin
         exp_q.push_back(mem[ad]);
      end
      for (int i = 0; i < 2 && wr; i++) begin
         if (be[i]) begin
            mem[ad][i] = w[i];
         end
      end
   endtask : model
   // Ready is a function of state, so sample it mid-cycle
   task automatic wait_ready(input logic beat);
      logic r;
      r = 1'b0;
      while (r !== 1'b1) begin
         @(negedge clk_sys);
         r = beat ? beat_ready : req_ready;
         @(posedge clk_sys);
      end
   endtask : wait_ready
   task automatic xfer(input logic wr, input logic burst, input psp_addr_t ad,
      input psp_be_t be, input int stall);
      psp_word_t w;
      w = 18'($random(seed));
      req_valid <= 1'b1;
      req_write <= wr;
      req_burst <= burst;
      req_addr <= ad;
      req_be <= be;
      req_wdata <= w;
      wait_ready(1'b0);
      req_valid <= 1'b0;
      model(ad, wr, be, w);
      for (int k = 1; k < 4 && burst; k++) begin
         w = 18'($random(seed));
         if (stall > 0) begin
            beat_valid <= 1'b0;
            repeat (stall) @(posedge clk_sys);
         end
         beat_valid <= 1'b1;
         beat_wdata <= w;
         wait_ready(1'b1);
         model(beat_addr(ad, order_interleaved, k), wr, be, w);
      end
      beat_valid <= 1'b0;
      @(posedge clk_sys);
   endtask : xfer
   always @(posedge clk_sys) begin
      if (rdata_valid === 1'b1 && exp_q.size() > 0) begin
         check_word(exp_q.pop_front(), rdata);
      end else if (rdata_valid === 1'b1) begin
         check_count(0, 1);
      end
   end
   initial begin
      seed = 32'h41cc;
      mismatches = 0;
      samples_checked = 0;
      rst = 1'b1;
      order_interleaved = 1'b0;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_burst = 1'b0;
      req_addr = '0;
      req_be = '0;
      req_wdata = '0;
      beat_valid = 1'b0;
      beat_wdata = '0;
      for (int o = 0; o < 2; o++) begin
         @(posedge clk_sys);
         do_reset(o[0]);
         for (int i = 0; i < 6; i++) begin
            a = 18'($random(seed));
            if (i == 0) begin
               a[1:0] = 2'h3;
            end
            xfer(1'b1, 1'b1, a, 2'h3, 0);
            xfer(1'b0, 1'b1, a, 2'h3, i % 3);
            xfer(1'b1, 1'b0, beat_addr(a, o[0], i), 2'(i % 3 + 1), 0);
            xfer(1'b0, 1'b0, beat_addr(a, o[0], i), 2'h3, 0);
         end
         repeat (10) @(posedge clk_sys);
         check_count(0, exp_q.size());
      end
      report_and_stop();
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      report_and_stop();
   end
endmodule : pipelined_burst_sram_port_bench
